// [core/tgw_gateway.sv]
// gateway end: event monitors, waits, barriers and use counts
`timescale 1ns/100ps
`default_nettype none
module tgw_gateway
  import tgw_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  tgw_link_if.gateway link,
  input wire logic dispatch_valid,
  input wire logic [BID_W-1:0] dispatch_bar,
  input wire logic [NUM_THREADS-1:0] dispatch_threads,
  input wire logic preempt,
  output logic [NUM_BARRIERS-1:0] bar_free,
  output logic slm_free
);
  logic [EVID_W-1:0] mon_id_reg [NUM_THREADS];
  logic [EVID_W-1:0] mon_id_next [NUM_THREADS];
  logic [NUM_THREADS-1:0] mon_on_reg, mon_on_next;
  logic [NUM_THREADS-1:0] rec_reg, rec_next;
  logic [NUM_THREADS-1:0] wait_reg, wait_next;
  logic [TMO_W-1:0] tmo_reg [NUM_THREADS];
  logic [TMO_W-1:0] tmo_next [NUM_THREADS];
  logic [NUM_THREADS-1:0] wb_ev_reg, wb_ev_next;
  logic [NUM_THREADS-1:0] wb_pend_reg, wb_pend_next;
  logic [TICK_W-1:0] tick_reg, tick_next;
  logic [NUM_THREADS-1:0] bar_mem_reg [NUM_BARRIERS];
  logic [NUM_THREADS-1:0] bar_mem_next [NUM_BARRIERS];
  logic [NUM_THREADS-1:0] bar_sig_reg [NUM_BARRIERS];
  logic [NUM_THREADS-1:0] bar_sig_next [NUM_BARRIERS];
  logic [CNT_W-1:0] bar_cnt_reg [NUM_BARRIERS];
  logic [CNT_W-1:0] bar_cnt_next [NUM_BARRIERS];
  logic [NUM_BARRIERS-1:0] bar_act_reg, bar_act_next;
  logic [CNT_W-1:0] slm_cnt_reg, slm_cnt_next;
  logic [NUM_THREADS-1:0] done_reg, done_next;
  logic wb_valid_reg, wb_valid_next;
  logic [TID_W-1:0] wb_tid_reg, wb_tid_next;
  logic wb_bit_reg, wb_bit_next;
  logic [NUM_BARRIERS-1:0] bar_free_reg, bar_free_next;
  logic slm_free_reg, slm_free_next;

  function automatic logic [CNT_W-1:0] popcnt(input logic [NUM_THREADS-1:0] v);
    logic [CNT_W-1:0] c;
    c = CNT_ZERO;
    for (int i = 0; i < NUM_THREADS; i++) begin
      c = c + CNT_W'(v[i]);
    end
    return c;
  endfunction

  function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] c);
    return (c == CNT_ZERO) ? CNT_ZERO : c - CNT_ONE;
  endfunction

  tgw_op_e op;
  logic take;
  logic [TID_W-1:0] tid;
  logic [EVID_W-1:0] ev_id;
  logic unit_tick;
  logic wb_found;

  assign link.req_ready = 1'b1;
  assign take = link.req_valid;
  assign op = link.req_op;
  assign tid = link.req_tid;
  assign ev_id = link.req_dw0[EVID_W-1:0];
  assign unit_tick = (tick_reg == TICK_LAST);

  always_comb begin
    mon_id_next = mon_id_reg;
    mon_on_next = mon_on_reg;
    rec_next = rec_reg;
    wait_next = wait_reg;
    tmo_next = tmo_reg;
    wb_ev_next = wb_ev_reg;
    wb_pend_next = wb_pend_reg;
    tick_next = unit_tick ? '0 : tick_reg + TICK_W'(1);
    bar_mem_next = bar_mem_reg;
    bar_sig_next = bar_sig_reg;
    bar_cnt_next = bar_cnt_reg;
    bar_act_next = bar_act_reg;
    slm_cnt_next = slm_cnt_reg;
    done_next = '0;
    wb_valid_next = 1'b0;
    wb_tid_next = wb_tid_reg;
    wb_bit_next = wb_bit_reg;
    wb_found = 1'b0;
    // timeouts count in units of 1024 clocks, first unit may be short
    for (int t = 0; t < NUM_THREADS; t++) begin
      if (wait_reg[t] && (preempt || (unit_tick && tmo_reg[t] <= TMO_W'(1)))) begin
        wait_next[t] = 1'b0;
        wb_pend_next[t] = 1'b1;
        wb_ev_next[t] = 1'b0;
      end else if (wait_reg[t] && unit_tick) begin
        tmo_next[t] = tmo_reg[t] - TMO_W'(1);
      end
    end
    if (take) begin
      unique case (op)
        TGW_OP_WATCH: begin
          mon_id_next[tid] = ev_id;
          mon_on_next[tid] = 1'b1;
          rec_next[tid] = 1'b0;
        end
        TGW_OP_WAIT: begin
          if (rec_reg[tid]) begin
            rec_next[tid] = 1'b0;
            wb_pend_next[tid] = 1'b1;
            wb_ev_next[tid] = 1'b1;
          end else begin
            wait_next[tid] = 1'b1;
            tmo_next[tid] = link.req_dw0[TMO_W-1:0];
          end
        end
        TGW_OP_SIGNAL: begin
          for (int t = 0; t < NUM_THREADS; t++) begin
            if (mon_on_reg[t] && mon_id_reg[t] == ev_id) begin
              if (wait_next[t]) begin
                wait_next[t] = 1'b0;
                wb_pend_next[t] = 1'b1;
                wb_ev_next[t] = 1'b1;
              end else begin
                rec_next[t] = 1'b1;
              end
            end
          end
        end
        TGW_OP_STOP: begin
          mon_on_next[tid] = 1'b0;
          rec_next[tid] = 1'b0;
        end
        TGW_OP_BARRIER: begin
          for (int b = 0; b < NUM_BARRIERS; b++) begin
            if (bar_act_reg[b] && bar_mem_reg[b][tid]) begin
              bar_sig_next[b][tid] = 1'b1;
            end
          end
        end
        TGW_OP_EXIT: begin
          mon_on_next[tid] = 1'b0;
          rec_next[tid] = 1'b0;
          wait_next[tid] = 1'b0;
          slm_cnt_next = dec_sat(slm_cnt_reg);
          for (int b = 0; b < NUM_BARRIERS; b++) begin
            if (bar_mem_reg[b][tid]) begin
              bar_mem_next[b][tid] = 1'b0;
              bar_sig_next[b][tid] = 1'b0;
              bar_cnt_next[b] = dec_sat(bar_cnt_reg[b]);
              if (bar_cnt_reg[b] == CNT_ONE) begin
                bar_act_next[b] = 1'b0;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
    // completion once every member has signalled; state back to idle
    for (int b = 0; b < NUM_BARRIERS; b++) begin
      if (bar_act_reg[b] && bar_mem_reg[b] != '0 && bar_sig_reg[b] == bar_mem_reg[b]) begin
        done_next = done_next | bar_mem_reg[b];
        bar_sig_next[b] = '0;
      end
    end
    if (dispatch_valid && !bar_act_reg[dispatch_bar]) begin
      bar_act_next[dispatch_bar] = 1'b1;
      bar_mem_next[dispatch_bar] = dispatch_threads;
      bar_sig_next[dispatch_bar] = '0;
      bar_cnt_next[dispatch_bar] = popcnt(dispatch_threads);
      // builds on any exit decrement taken in the same cycle
      slm_cnt_next = slm_cnt_next + popcnt(dispatch_threads);
    end
    // one writeback per clock, lowest thread first
    for (int t = 0; t < NUM_THREADS; t++) begin
      if (wb_pend_reg[t] && !wb_found) begin
        wb_found = 1'b1;
        wb_pend_next[t] = 1'b0;
        wb_valid_next = 1'b1;
        wb_tid_next = TID_W'(t);
        wb_bit_next = wb_ev_reg[t];
      end
    end
    for (int b = 0; b < NUM_BARRIERS; b++) begin
      bar_free_next[b] = !bar_act_next[b];
    end
    slm_free_next = (slm_cnt_next == CNT_ZERO);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        mon_id_reg[t] <= '0;
        tmo_reg[t] <= '0;
      end
      for (int b = 0; b < NUM_BARRIERS; b++) begin
        bar_mem_reg[b] <= '0;
        bar_sig_reg[b] <= '0;
        bar_cnt_reg[b] <= CNT_ZERO;
      end
      mon_on_reg <= '0;
      rec_reg <= '0;
      wait_reg <= '0;
      wb_ev_reg <= '0;
      wb_pend_reg <= '0;
      tick_reg <= '0;
      bar_act_reg <= '0;
      slm_cnt_reg <= CNT_ZERO;
      done_reg <= '0;
      wb_valid_reg <= 1'b0;
      wb_tid_reg <= '0;
      wb_bit_reg <= 1'b0;
      bar_free_reg <= '1;
      slm_free_reg <= 1'b1;
    end else begin
      mon_id_reg <= mon_id_next;
      tmo_reg <= tmo_next;
      bar_mem_reg <= bar_mem_next;
      bar_sig_reg <= bar_sig_next;
      bar_cnt_reg <= bar_cnt_next;
      mon_on_reg <= mon_on_next;
      rec_reg <= rec_next;
      wait_reg <= wait_next;
      wb_ev_reg <= wb_ev_next;
      wb_pend_reg <= wb_pend_next;
      tick_reg <= tick_next;
      bar_act_reg <= bar_act_next;
      slm_cnt_reg <= slm_cnt_next;
      done_reg <= done_next;
      wb_valid_reg <= wb_valid_next;
      wb_tid_reg <= wb_tid_next;
      wb_bit_reg <= wb_bit_next;
      bar_free_reg <= bar_free_next;
      slm_free_reg <= slm_free_next;
    end
  end

  assign link.wb_valid = wb_valid_reg;
  assign link.wb_tid = wb_tid_reg;
  assign link.wb_dw0 = {{(DW_W-1){1'b0}}, wb_bit_reg};
  assign link.bar_done = done_reg;
  assign bar_free = bar_free_reg;
  assign slm_free = slm_free_reg;
endmodule
`default_nettype wire

// [core/tgw_link_if.sv]
// request and answer channel between threads and the gateway
`timescale 1ns/100ps
`default_nettype none
interface tgw_link_if;
  import tgw_pkg::*;
  logic req_valid;
  logic req_ready;
  tgw_op_e req_op;
  logic [TID_W-1:0] req_tid;
  logic [DW_W-1:0] req_dw0;
  logic wb_valid;
  logic [TID_W-1:0] wb_tid;
  logic [DW_W-1:0] wb_dw0;
  logic [NUM_THREADS-1:0] bar_done;
  modport gateway (input req_valid, req_op, req_tid, req_dw0,
                   output req_ready, wb_valid, wb_tid, wb_dw0, bar_done);
  modport threads (output req_valid, req_op, req_tid, req_dw0,
                   input req_ready, wb_valid, wb_tid, wb_dw0, bar_done);
endinterface
`default_nettype wire

// [core/tgw_pkg.sv]
// constants and types shared by the thread gateway ends
// Behaviour
// - writeback bit0: 1 event, 0 timeout
// - signal records event for matching monitors
// - signal wakes matching threads with waits
// - identifier from bits 23:0 only
// - stop request clears sender's monitoring
// - thread exit also clears monitoring
// - notify barrier threads once all signalled
// - barrier inactive at allocation and completion
// - barrier allocated at dispatch, freed after exits
// - thread awaits barrier completion before exiting
// - thread signals barrier then waits completion
// - receiver watches, waits, then checks semaphore
// - signaller updates memory atomically before signalling
// - exit drops tracking, decrements use counts
// - zero use count frees the resource
// - one monitor per thread, new clears recorded
// - wait answered on event or immediately if recorded
// - timeout bits 9:0 times 1024 clocks
// - preemption ends outstanding waits with timeout
package tgw_pkg;
  localparam int NUM_THREADS = 8;
  localparam int TID_W = 3;
  localparam int NUM_BARRIERS = 4;
  localparam int BID_W = 2;
  localparam int EVID_W = 24;
  localparam int DW_W = 32;
  localparam int TMO_W = 10;
  localparam int TMO_UNIT_CLKS = 1024;
  localparam int TICK_W = 10;
  localparam int CNT_W = 4;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TMO_UNIT_CLKS - 1);
  localparam logic [TMO_W-1:0] TMO_MIN_LEGAL = 10'h002;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam int WB_EVENT_BIT = 0;
  typedef enum logic [2:0] {
    TGW_OP_NONE = 3'h0,
    TGW_OP_WATCH = 3'h1,
    TGW_OP_WAIT = 3'h2,
    TGW_OP_SIGNAL = 3'h3,
    TGW_OP_STOP = 3'h4,
    TGW_OP_BARRIER = 3'h5,
    TGW_OP_EXIT = 3'h6
  } tgw_op_e;
endpackage

// [core/tgw_thread_port.sv]
// thread end: issues one gateway request at a time and collects answers
`timescale 1ns/100ps
`default_nettype none
module tgw_thread_port
  import tgw_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  tgw_link_if.threads link,
  input wire logic cmd_valid,
  input wire tgw_op_e cmd_op,
  input wire logic [TID_W-1:0] cmd_tid,
  input wire logic [DW_W-1:0] cmd_dw0,
  output logic cmd_ready,
  output logic [NUM_THREADS-1:0] wait_pending,
  output logic [NUM_THREADS-1:0] bar_pending,
  output logic wake_valid,
  output logic [TID_W-1:0] wake_tid,
  output logic wake_event
);
  logic req_valid_reg, req_valid_next;
  tgw_op_e req_op_reg, req_op_next;
  logic [TID_W-1:0] req_tid_reg, req_tid_next;
  logic [DW_W-1:0] req_dw0_reg, req_dw0_next;
  logic [NUM_THREADS-1:0] wpend_reg, wpend_next;
  logic [NUM_THREADS-1:0] bpend_reg, bpend_next;
  logic wake_valid_reg, wake_valid_next;
  logic [TID_W-1:0] wake_tid_reg, wake_tid_next;
  logic wake_event_reg, wake_event_next;
  logic cmd_ready_reg, cmd_ready_next;
  logic accept;

  // an exit is held back while the thread awaits a barrier; a pending wait does not hold it
  // a wait with an illegal timeout is dropped
  always_comb begin
    accept = 1'b0;
    if (cmd_valid && !req_valid_reg) begin
      accept = !(cmd_op == TGW_OP_EXIT && bpend_reg[cmd_tid])
        && !(cmd_op == TGW_OP_WAIT && cmd_dw0[TMO_W-1:0] < TMO_MIN_LEGAL)
        && !((cmd_op == TGW_OP_WAIT || cmd_op == TGW_OP_BARRIER)
             && (wpend_reg[cmd_tid] || bpend_reg[cmd_tid]));
    end
  end

  always_comb begin
    req_valid_next = req_valid_reg;
    req_op_next = req_op_reg;
    req_tid_next = req_tid_reg;
    req_dw0_next = req_dw0_reg;
    wpend_next = wpend_reg;
    bpend_next = bpend_reg & ~link.bar_done;
    wake_valid_next = link.wb_valid;
    wake_tid_next = link.wb_valid ? link.wb_tid : wake_tid_reg;
    wake_event_next = link.wb_valid ? link.wb_dw0[WB_EVENT_BIT] : wake_event_reg;
    if (link.wb_valid) begin
      wpend_next[link.wb_tid] = 1'b0;
    end
    if (req_valid_reg && link.req_ready) begin
      req_valid_next = 1'b0;
    end
    if (accept) begin
      req_valid_next = 1'b1;
      req_op_next = cmd_op;
      req_tid_next = cmd_tid;
      req_dw0_next = cmd_dw0;
      if (cmd_op == TGW_OP_WAIT) begin
        wpend_next[cmd_tid] = 1'b1;
      end
      if (cmd_op == TGW_OP_BARRIER) begin
        bpend_next[cmd_tid] = 1'b1;
      end
    end
    cmd_ready_next = !req_valid_next;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_valid_reg <= 1'b0;
      req_op_reg <= TGW_OP_NONE;
      req_tid_reg <= '0;
      req_dw0_reg <= '0;
      wpend_reg <= '0;
      bpend_reg <= '0;
      wake_valid_reg <= 1'b0;
      wake_tid_reg <= '0;
      wake_event_reg <= 1'b0;
      cmd_ready_reg <= 1'b1;
    end else begin
      req_valid_reg <= req_valid_next;
      req_op_reg <= req_op_next;
      req_tid_reg <= req_tid_next;
      req_dw0_reg <= req_dw0_next;
      wpend_reg <= wpend_next;
      bpend_reg <= bpend_next;
      wake_valid_reg <= wake_valid_next;
      wake_tid_reg <= wake_tid_next;
      wake_event_reg <= wake_event_next;
      cmd_ready_reg <= cmd_ready_next;
    end
  end

  assign link.req_valid = req_valid_reg;
  assign link.req_op = req_op_reg;
  assign link.req_tid = req_tid_reg;
  assign link.req_dw0 = req_dw0_reg;
  assign cmd_ready = cmd_ready_reg;
  assign wait_pending = wpend_reg;
  assign bar_pending = bpend_reg;
  assign wake_valid = wake_valid_reg;
  assign wake_tid = wake_tid_reg;
  assign wake_event = wake_event_reg;
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench joining the gateway end and the thread end
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tgw_pkg::*;
  logic core_clk;
  logic srst;
  logic cmd_valid;
  tgw_op_e cmd_op;
  logic [TID_W-1:0] cmd_tid;
  logic [DW_W-1:0] cmd_dw0;
  logic cmd_ready;
  logic wake_valid;
  logic [TID_W-1:0] wake_tid;
  logic wake_event;
  logic dispatch_valid;
  logic [BID_W-1:0] dispatch_bar;
  logic [NUM_THREADS-1:0] dispatch_threads;
  logic preempt;
  logic [NUM_BARRIERS-1:0] bar_free;
  logic slm_free;
  logic [NUM_THREADS-1:0] done_seen;
  logic [NUM_THREADS-1:0] wait_pending;
  logic [NUM_THREADS-1:0] bar_pending;
  logic [DW_W-1:0] seed;
  logic [DW_W-1:0] id;
  logic ev [NUM_THREADS];
  int got [NUM_THREADS];
  int mismatches;
  int total_checks;
  tgw_link_if link ();
  tgw_gateway u_tgw_gateway (
    .core_clk(core_clk), .srst(srst), .link(link.gateway), .dispatch_valid(dispatch_valid),
    .dispatch_bar(dispatch_bar), .dispatch_threads(dispatch_threads), .preempt(preempt),
    .bar_free(bar_free), .slm_free(slm_free)
  );
  tgw_thread_port u_tgw_thread_port (
    .core_clk(core_clk), .srst(srst), .link(link.threads), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_tid(cmd_tid), .cmd_dw0(cmd_dw0), .cmd_ready(cmd_ready),
    .wait_pending(wait_pending), .bar_pending(bar_pending), .wake_valid(wake_valid),
    .wake_tid(wake_tid),
    .wake_event(wake_event)
  );
  tgw_checker u_tgw_checker (
    .core_clk(core_clk), .srst(srst), .req_valid(link.req_valid), .req_ready(link.req_ready),
    .req_op(link.req_op), .req_tid(link.req_tid), .req_dw0(link.req_dw0),
    .wb_valid(link.wb_valid), .wb_tid(link.wb_tid), .wb_dw0(link.wb_dw0),
    .bar_done(link.bar_done)
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (wake_valid === 1'b1) begin
      got[wake_tid]++;
      ev[wake_tid] = wake_event;
    end
    done_seen = done_seen | link.bar_done;
  end
  function automatic logic [DW_W-1:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // earliest legal timeout answer, counted from the end of the wait request
  function automatic int tmo_lo(input int units);
    return (units - 1) * TMO_UNIT_CLKS - 8;
  endfunction
  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input tgw_op_e op, input int tid, input logic [DW_W-1:0] dw);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_tid = tid[TID_W-1:0];
    cmd_dw0 = dw;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      end_of_test();
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic wake_chk(input int tid, input logic [TMO_W-1:0] tmo, input logic exp_ev,
                          input int lo, input int hi, input logic pre);
    int n;
    logic [DW_W-1:0] r;
    n = 0;
    r = rnd();
    got[tid] = 0;
    send(TGW_OP_WAIT, tid, {r[DW_W-1:TMO_W], tmo});
    chk(32'(wait_pending[tid]), 32'h1);
    while (got[tid] == 0 && n < hi) begin
      preempt = pre && n < 4;
      @(negedge core_clk);
      n++;
    end
    preempt = 1'b0;
    chk(32'({got[tid] == 1, ev[tid]}), 32'({1'b1, exp_ev}));
    chk(32'(n >= lo), 32'h1);
    chk(32'(wait_pending[tid]), 32'h0);
    if (got[tid] == 0) end_of_test();
  endtask
  initial begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = TGW_OP_NONE;
    cmd_tid = '0;
    cmd_dw0 = '0;
    dispatch_valid = 1'b0;
    dispatch_bar = '0;
    dispatch_threads = '0;
    preempt = 1'b0;
    done_seen = '0;
    seed = 32'h0000_0063;
    mismatches = 0;
    total_checks = 0;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    chk(32'({bar_free, slm_free, cmd_ready}), 32'h3F);
    // the near miss differs from the signalled identifier in one bit
    for (int i = 0; i < 4; i++) begin
      id = rnd();
      send(TGW_OP_WATCH, 1, id);
      send(TGW_OP_WATCH, 2, id ^ (32'h1 << (i * 7)));
      send(TGW_OP_SIGNAL, 0, {~id[31:24], id[23:0]});
      wake_chk(1, 10'h3FF, 1'b1, 0, 40, 1'b0);
      wake_chk(2, 10'h002, 1'b0, tmo_lo(2), 2064, 1'b0);
    end
    id = rnd();
    send(TGW_OP_WATCH, 3, id);
    send(TGW_OP_WATCH, 4, id);
    got[3] = 0;
    got[4] = 0;
    send(TGW_OP_WAIT, 3, 32'h0000_03FF);
    send(TGW_OP_WAIT, 4, 32'h0000_03FF);
    send(TGW_OP_SIGNAL, 5, id);
    repeat (8) @(negedge core_clk);
    chk(32'({got[3] == 1, got[4] == 1, ev[3], ev[4]}), 32'hF);
    send(TGW_OP_WATCH, 3, id);
    send(TGW_OP_SIGNAL, 0, id);
    send(TGW_OP_WATCH, 3, ~id);
    wake_chk(3, 10'h002, 1'b0, tmo_lo(2), 2064, 1'b0);
    for (int k = 0; k < 2; k++) begin
      id = rnd();
      send(TGW_OP_WATCH, 4, id);
      send(k == 0 ? TGW_OP_STOP : TGW_OP_EXIT, 4, rnd());
      send(TGW_OP_SIGNAL, 0, id);
      wake_chk(4, 10'h002, 1'b0, tmo_lo(2), 2064, 1'b0);
    end
    send(TGW_OP_WATCH, 6, id);
    got[6] = 0;
    send(TGW_OP_WAIT, 6, 32'h0000_03FF);
    send(TGW_OP_EXIT, 6, '0);
    send(TGW_OP_SIGNAL, 0, id);
    repeat (8) @(negedge core_clk);
    chk(32'(got[6]), 32'h0);
    send(TGW_OP_WATCH, 7, rnd());
    wake_chk(7, 10'h3FF, 1'b0, 0, 40, 1'b1);
    dispatch_bar = 2'h1;
    dispatch_threads = 8'h0C;
    dispatch_valid = 1'b1;
    @(negedge core_clk);
    dispatch_valid = 1'b0;
    @(negedge core_clk);
    chk(32'({bar_free, slm_free}), 32'h1A);
    for (int r = 0; r < 2; r++) begin
      done_seen = '0;
      send(TGW_OP_BARRIER, 2, '0);
      if (r == 0) send(TGW_OP_EXIT, 2, '0);
      repeat (4) @(negedge core_clk);
      chk(32'({done_seen, bar_pending}), 32'h0004);
      send(TGW_OP_BARRIER, 3, '0);
      repeat (4) @(negedge core_clk);
      chk(32'({done_seen, bar_pending}), 32'h0C00);
    end
    send(TGW_OP_EXIT, 2, '0);
    repeat (2) @(negedge core_clk);
    chk(32'({bar_free, slm_free}), 32'h1A);
    send(TGW_OP_EXIT, 3, '0);
    repeat (2) @(negedge core_clk);
    chk(32'({bar_free, slm_free}), 32'h1F);
    end_of_test();
  end
endmodule
`default_nettype wire

// [verif/tgw_checker.sv]
// assertions on the link between the thread end and the gateway end
`timescale 1ns/100ps
`default_nettype none
module tgw_checker
  import tgw_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire tgw_op_e req_op,
  input wire logic [TID_W-1:0] req_tid,
  input wire logic [DW_W-1:0] req_dw0,
  input wire logic wb_valid,
  input wire logic [TID_W-1:0] wb_tid,
  input wire logic [DW_W-1:0] wb_dw0,
  input wire logic [NUM_THREADS-1:0] bar_done
);
  logic [NUM_THREADS-1:0] wait_reg;
  logic [NUM_THREADS-1:0] wait_next;
  logic [NUM_THREADS-1:0] sig_reg;
  logic [NUM_THREADS-1:0] sig_next;
  logic take;
  assign take = req_valid && req_ready;
  // threads with a wait outstanding, threads that signalled a barrier
  always_comb begin
    wait_next = wait_reg;
    sig_next = sig_reg & ~bar_done;
    if (wb_valid) wait_next[wb_tid] = 1'b0;
    if (take && req_op == TGW_OP_WAIT) wait_next[req_tid] = 1'b1;
    if (take && req_op == TGW_OP_EXIT) wait_next[req_tid] = 1'b0;
    if (take && req_op == TGW_OP_BARRIER) sig_next[req_tid] = 1'b1;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_reg <= '0;
      sig_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      sig_reg <= sig_next;
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_wb_upper_zero: assert property (wb_valid |-> wb_dw0[31:1] == '0)
    else $error("writeback upper bits set");
  a_wb_after_wait: assert property (wb_valid |-> wait_reg[wb_tid])
    else $error("writeback without wait");
  a_wb_one_each: assert property (wb_valid ##1 wb_valid |-> wb_tid != $past(wb_tid))
    else $error("repeated writeback");
  a_exit_silent: assert property (
    take && req_op == TGW_OP_EXIT && wait_reg[req_tid]
    |-> ##2 !(wb_valid && wb_tid == $past(req_tid, 2)))
    else $error("writeback after exit");
  a_bar_last_signal: assert property (bar_done != '0 |-> $past(take, 2) &&
    $past(req_op, 2) == TGW_OP_BARRIER && bar_done[$past(req_tid, 2)])
    else $error("barrier done without last signal");
  a_bar_members: assert property ((bar_done & ~sig_reg) == '0)
    else $error("barrier done to idle thread");
  a_bar_no_repeat: assert property (bar_done != '0 |=> (bar_done & $past(bar_done)) == '0)
    else $error("barrier done repeated");
  a_reset_quiet: assert property ($fell(srst) |-> !wb_valid && bar_done == '0)
    else $error("output active after reset");
  c_event_wake: cover property (wb_valid && wb_dw0[0]);
  c_timeout_wake: cover property (wb_valid && !wb_dw0[0]);
  c_barrier_done: cover property (bar_done != '0);
endmodule
`default_nettype wire
